/* File: logic/dual_duty_cycle_modulator.sv */
// Two-line duty-cycle modulator with 16 kHz tone option, AXI4-Lite register slave

module dual_duty_cycle_modulator #(
   parameter int AW = 12
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // AXI4-Lite write address
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Modulated lines
   output pwm_pkg::pin_s modulated_out_a,
   output pwm_pkg::pin_s modulated_out_b
);
   import pwm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic aw_full_r, w_full_r, wlane_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic do_write, slot_tick, wrap, tone_sq_r;
   logic [AW-1:0] awaddr_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   reg_sel_e wsel, rsel;
   logic [7:0] wdata_r, config_r, style_r, slot_r;
   logic [7:0] duty_r [2], duty_act_r [2], acc_r [2];
   logic [FRQ_W-1:0] frq_act_r;
   logic [9:0] pre_r, pre_last;
   logic [11:0] tone_cnt_r;
   logic [17:0] per_cnt_r;
   logic [8:0] acc_sum [2], high_cnt_r [2];
   logic tone_en [2], level_r [2], src [2], last_carry_r [2];
   drive_style_e line_style [2];
   pin_s pin_r [2];

   function automatic reg_sel_e decode(input logic [AW-1:0] a);
      if (a == AW'({IDX_CONFIG, 2'b00})) begin
         return SEL_CONFIG;
      end else if (a == AW'({IDX_DUTY_A, 2'b00})) begin
         return SEL_DUTY_A;
      end else if (a == AW'({IDX_DUTY_B, 2'b00})) begin
         return SEL_DUTY_B;
      end else if (a == AW'({IDX_STYLE, 2'b00})) begin
         return SEL_STYLE;
      end else if (a == AW'({IDX_STATUS, 2'b00})) begin
         return SEL_STATUS;
      end else begin
         return SEL_NONE;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path: address and data taken in either order

   assign do_write = aw_full_r && w_full_r && !bvalid_r;
   assign wsel = decode(awaddr_r);
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         aw_full_r <= 1'b0;
         awready_r <= 1'b0;
         awaddr_r <= '0;
      end else if (s_axi_awvalid && awready_r) begin
         aw_full_r <= 1'b1;
         awready_r <= 1'b0;
         awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
         aw_full_r <= 1'b0;
      end else if (!aw_full_r && !bvalid_r) begin
         awready_r <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         w_full_r <= 1'b0;
         wready_r <= 1'b0;
         wdata_r <= 8'h00;
         wlane_r <= 1'b0;
      end else if (s_axi_wvalid && wready_r) begin
         w_full_r <= 1'b1;
         wready_r <= 1'b0;
         wdata_r <= s_axi_wdata[7:0];
         wlane_r <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_full_r <= 1'b0;
      end else if (!w_full_r && !bvalid_r) begin
         wready_r <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_r <= 1'b1;
         bresp_r <= (wsel == SEL_NONE || wsel == SEL_STATUS) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end
   // Registers hold only the low byte; other lanes are ignored
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         config_r <= CONFIG_RST;
         style_r <= STYLE_RST;
         duty_r[0] <= DUTY_RST;
         duty_r[1] <= DUTY_RST;
      end else if (do_write && wlane_r) begin
         if (wsel == SEL_CONFIG) begin
            config_r <= wdata_r;
         end else if (wsel == SEL_DUTY_A) begin
            duty_r[0] <= wdata_r;
         end else if (wsel == SEL_DUTY_B) begin
            duty_r[1] <= wdata_r;
         end else if (wsel == SEL_STYLE) begin
            style_r <= wdata_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path

   assign rsel = decode(s_axi_araddr);
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else if (s_axi_arvalid && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rresp_r <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         if (rsel == SEL_CONFIG) begin
            rdata_r <= {24'h000000, config_r};
         end else if (rsel == SEL_DUTY_A) begin
            rdata_r <= {24'h000000, duty_r[0]};
         end else if (rsel == SEL_DUTY_B) begin
            rdata_r <= {24'h000000, duty_r[1]};
         end else if (rsel == SEL_STYLE) begin
            rdata_r <= {24'h000000, style_r};
         end else if (rsel == SEL_STATUS) begin
            rdata_r <= {29'h00000000, tone_sq_r, level_r[1], level_r[0]};
         end else begin
            rdata_r <= 32'h0000_0000;
         end
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end else if (!rvalid_r) begin
         arready_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shared period timing: 256 slots, each 8^freq cycles long

   assign pre_last = 10'((11'h001 << (FRQ_MUL * int'(frq_act_r))) - 11'h001);
   assign slot_tick = (pre_r == pre_last);
   assign wrap = slot_tick && (slot_r == 8'hFF);
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         pre_r <= 10'h000;
         slot_r <= 8'h00;
      end else if (slot_tick) begin
         pre_r <= 10'h000;
         slot_r <= slot_r + 8'h01;
      end else begin
         pre_r <= pre_r + 10'h001;
      end
   end
   // Frequency and duty are adopted only at the wrap so a running period never glitches; style and tone enables act at once
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         frq_act_r <= '0;
         duty_act_r[0] <= DUTY_RST;
         duty_act_r[1] <= DUTY_RST;
      end else if (wrap) begin
         frq_act_r <= config_r[CFG_FRQ_LSB +: FRQ_W];
         duty_act_r[0] <= duty_r[0];
         duty_act_r[1] <= duty_r[1];
      end
   end
   // Free-running tone; both lines share one square wave
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         tone_cnt_r <= 12'h000;
         tone_sq_r <= 1'b0;
      end else if (tone_cnt_r == 12'(TONE_HALF - 1)) begin
         tone_cnt_r <= 12'h000;
         tone_sq_r <= !tone_sq_r;
      end else begin
         tone_cnt_r <= tone_cnt_r + 12'h001;
      end
   end
   assign tone_en[0] = config_r[CFG_TONE_A];
   assign tone_en[1] = config_r[CFG_TONE_B];
   assign line_style[0] = drive_style_e'(style_r[STYLE_A_LSB +: 2]);
   assign line_style[1] = drive_style_e'(style_r[STYLE_B_LSB +: 2]);

   ////////////////////////////////////////////////////////////////////////////////
   // Per-line modulator and driver

   generate
      for (genvar k = 0; k < 2; k++) begin : g_line
         // Accumulator overflow spreads duty slots evenly; it returns to zero each period
         assign acc_sum[k] = {1'b0, acc_r[k]} + {1'b0, duty_act_r[k]};
         always_ff @(posedge core_clk) begin
            if (!nrst) begin
               acc_r[k] <= 8'h00;
               level_r[k] <= 1'b0;
            end else if (slot_tick) begin
               acc_r[k] <= acc_sum[k][7:0];
               level_r[k] <= acc_sum[k][8];
            end
         end
         assign src[k] = tone_en[k] ? tone_sq_r : level_r[k];
         always_ff @(posedge core_clk) begin
            if (!nrst) begin
               pin_r[k] <= '0;
            end else begin
               case (line_style[k])
                  STYLE_OPEN_DRAIN: pin_r[k] <= '{o: 1'b0, oe: !src[k]};
                  STYLE_OPEN_SOURCE: pin_r[k] <= '{o: 1'b1, oe: src[k]};
                  STYLE_PUSH_PULL: pin_r[k] <= '{o: src[k], oe: 1'b1};
                  default: pin_r[k] <= '{o: 1'b0, oe: 1'b0};
               endcase
            end
         end
         // Helper state read only by the checks below
         always_ff @(posedge core_clk) begin
            if (!nrst) begin
               high_cnt_r[k] <= 9'h000;
               last_carry_r[k] <= 1'b0;
            end else if (slot_tick) begin
               high_cnt_r[k] <= wrap ? 9'h000 : high_cnt_r[k] + 9'(acc_sum[k][8]);
               last_carry_r[k] <= acc_sum[k][8];
            end
         end
         a_zero_duty_low: assert property (@(posedge core_clk) disable iff (!nrst)
            (slot_tick && duty_act_r[k] == 8'h00) |=> !level_r[k])
            else $error("line high with zero duty");
         a_high_slot_count: assert property (@(posedge core_clk) disable iff (!nrst)
            wrap |-> (high_cnt_r[k] + 9'(acc_sum[k][8])) == {1'b0, duty_act_r[k]})
            else $error("high slot count differs from duty");
         a_even_spread: assert property (@(posedge core_clk) disable iff (!nrst)
            (slot_tick && acc_sum[k][8] && duty_act_r[k] <= 8'h80) |-> !last_carry_r[k])
            else $error("high slots bunched");
         a_level_on_slot: assert property (@(posedge core_clk) disable iff (!nrst)
            $changed(level_r[k]) |-> $past(slot_tick))
            else $error("level changed inside a slot");
         a_duty_latch: assert property (@(posedge core_clk) disable iff (!nrst)
            $changed(duty_act_r[k]) |-> $past(wrap))
            else $error("duty adopted mid period");
         a_drain_style: assert property (@(posedge core_clk) disable iff (!nrst)
            (line_style[k] == STYLE_OPEN_DRAIN) |=> (!pin_r[k].o && pin_r[k].oe == !$past(src[k])))
            else $error("open drain driving high");
         a_tone_follow: assert property (@(posedge core_clk) disable iff (!nrst)
            (tone_en[k] && line_style[k] == STYLE_PUSH_PULL) |=> pin_r[k].o == $past(tone_sq_r))
            else $error("tone not on push pull line");
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (!nrst || wrap) begin
         per_cnt_r <= 18'h00000;
      end else begin
         per_cnt_r <= per_cnt_r + 18'h00001;
      end
   end

   a_period_length: assert property (@(posedge core_clk) disable iff (!nrst)
      wrap |-> per_cnt_r == 18'((19'(SLOTS) << (FRQ_MUL * int'(frq_act_r))) - 19'h00001))
      else $error("period length wrong");
   a_reset_clear: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(nrst) |-> (duty_r[0] == 8'h00 && duty_r[1] == 8'h00 && config_r == 8'h00))
      else $error("settings not cleared by reset");
   a_tone_half: assert property (@(posedge core_clk) disable iff (!nrst)
      (tone_cnt_r == 12'(TONE_HALF - 1)) |=> $changed(tone_sq_r) ##1 $stable(tone_sq_r))
      else $error("tone half period wrong");
   a_resp_after_both: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(bvalid_r) |-> $past(aw_full_r && w_full_r))
      else $error("write answered early");

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign modulated_out_a = pin_r[0];
   assign modulated_out_b = pin_r[1];

endmodule

/* File: shared/pwm_pkg.sv */
// Constants, register map and carrier types for the dual duty-cycle modulator
package pwm_pkg;

   // Timing
   localparam int CLK_HZ = 100_000_000;
   localparam int TONE_HZ = 16_000;
   localparam int TONE_HALF = CLK_HZ / (2 * TONE_HZ);
   localparam int SLOTS = 256;
   localparam int FRQ_MUL = 3;
   localparam int FRQ_W = 2;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CONFIG = 8'h1E;
   localparam logic [7:0] IDX_DUTY_A = 8'h38;
   localparam logic [7:0] IDX_DUTY_B = 8'h39;
   localparam logic [7:0] IDX_STYLE = 8'h46;
   localparam logic [7:0] IDX_STATUS = 8'h47;

   // Field positions
   localparam int CFG_FRQ_LSB = 0;
   localparam int CFG_TONE_A = 4;
   localparam int CFG_TONE_B = 5;
   localparam int STYLE_A_LSB = 0;
   localparam int STYLE_B_LSB = 2;
   localparam int STAT_LEVEL_A = 0;
   localparam int STAT_LEVEL_B = 1;
   localparam int STAT_TONE = 2;

   // Reset values
   localparam logic [7:0] CONFIG_RST = 8'h00;
   localparam logic [7:0] DUTY_RST = 8'h00;
   localparam logic [7:0] STYLE_RST = 8'h00;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      STYLE_OFF = 2'h0,
      STYLE_OPEN_DRAIN = 2'h1,
      STYLE_OPEN_SOURCE = 2'h2,
      STYLE_PUSH_PULL = 2'h3
   } drive_style_e;

   typedef enum logic [2:0] {
      SEL_NONE = 3'h0,
      SEL_CONFIG = 3'h1,
      SEL_DUTY_A = 3'h2,
      SEL_DUTY_B = 3'h3,
      SEL_STYLE = 3'h4,
      SEL_STATUS = 3'h5
   } reg_sel_e;

   // Pin carrier: output level and output enable
   typedef struct packed {
      logic o;
      logic oe;
   } pin_s;

endpackage

/* File: testbench/line_load_model.sv */
// Load model for one modulated line: pull resistor and integrating counters
module line_load_model (
   // Clock and window control
   input logic core_clk,
   input logic clr,
   // Line and external pull level
   input pwm_pkg::pin_s pin,
   input logic pull_lvl,
   // Observations over the window
   output logic wire_lvl,
   output logic [31:0] hi_cnt,
   output logic [31:0] dhi_cnt,
   output logic [31:0] dlo_cnt,
   output logic [31:0] rise_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   import pwm_pkg::*;
   logic prev_r;
   ////////////////////////////////////////////////////////////////////////////////
   // A released line settles to the external pull, never to its last driven value
   assign wire_lvl = pin.oe ? pin.o : pull_lvl;
   always_ff @(posedge core_clk) begin
      prev_r <= wire_lvl;
      if (clr) begin
         hi_cnt <= 32'h0;
         dhi_cnt <= 32'h0;
         dlo_cnt <= 32'h0;
         rise_cnt <= 32'h0;
      end else begin
         hi_cnt <= hi_cnt + 32'(wire_lvl);
         dhi_cnt <= dhi_cnt + 32'(pin.oe & pin.o);
         dlo_cnt <= dlo_cnt + 32'(pin.oe & ~pin.o);
         rise_cnt <= rise_cnt + 32'(wire_lvl & ~prev_r);
      end
   end
endmodule

/* File: testbench/dual_duty_cycle_modulator_tb_top.sv */
// Self-checking bench for the dual duty-cycle modulator
module dual_duty_cycle_modulator_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pwm_pkg::*;
   typedef struct {logic [7:0] da; logic [7:0] db; logic [1:0] f; logic [1:0] sa; logic [1:0] sb;} row_s;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata, rd;
   pin_s pin_a, pin_b;
   logic clr = 1'b0, pull_a = 1'b0, pull_b = 1'b0;
   logic [31:0] hi_a, dhi_a, dlo_a, rs_a, hi_b, dhi_b, dlo_b, rs_b;
   int errors = 0;
   int n_tests = 0;
   int per;
   // Slow rows last: a period change only lands at the next wrap
   row_s rows [6] = '{'{8'h00, 8'hFF, 2'h0, 2'h3, 2'h3}, '{8'h01, 8'h80, 2'h0, 2'h3, 2'h1},
      '{8'h80, 8'h03, 2'h0, 2'h2, 2'h3}, '{8'hFF, 8'h40, 2'h0, 2'h1, 2'h2},
      '{8'h40, 8'h01, 2'h1, 2'h3, 2'h3}, '{8'h05, 8'hC8, 2'h2, 2'h3, 2'h3}};
   ////////////////////////////////////////////////////////////////////////////////
   always #5 core_clk = ~core_clk;
   dual_duty_cycle_modulator u_dut (.core_clk(core_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .modulated_out_a(pin_a), .modulated_out_b(pin_b));
   line_load_model u_load_a (.core_clk(core_clk), .clr(clr), .pin(pin_a), .pull_lvl(pull_a),
      .wire_lvl(), .hi_cnt(hi_a), .dhi_cnt(dhi_a), .dlo_cnt(dlo_a), .rise_cnt(rs_a));
   line_load_model u_load_b (.core_clk(core_clk), .clr(clr), .pin(pin_b), .pull_lvl(pull_b),
      .wire_lvl(), .hi_cnt(hi_b), .dhi_cnt(dhi_b), .dlo_cnt(dlo_b), .rise_cnt(rs_b));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      resp = 2'h3;
      @(posedge core_clk);
      awaddr <= {2'h0, idx, 2'h0};
      wdata <= {24'h0, d};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (n < 100) begin
         @(posedge core_clk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            resp = bresp;
            bready <= 1'b0;
            n = 1000;
         end
      end
      chk(32'(n), 32'd1000, "write answer");
   endtask
   task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      resp = 2'h3;
      d = 32'hFFFFFFFF;
      @(posedge core_clk);
      araddr <= {2'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (n < 100) begin
         @(posedge core_clk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            resp = rresp;
            rready <= 1'b0;
            n = 1000;
         end
      end
      chk(32'(n), 32'd1000, "read answer");
   endtask
   task automatic measure(input int cycles);
      @(posedge core_clk);
      clr <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
      repeat (cycles) @(posedge core_clk);
      #1;
   endtask
   task automatic chk_line(input logic [31:0] hi, dhi, dlo, rs, input logic [7:0] d,
                           input logic [1:0] f, input logic [1:0] s);
      logic [31:0] h;
      logic [31:0] p;
      h = {24'h0, d} << (3 * f);
      p = 32'h100 << (3 * f);
      chk(hi, h, "high time");
      chk(dhi, (s[1] ? h : 32'h0), "driven high");
      chk(dlo, (s[0] ? p - h : 32'h0), "driven low");
      if (d <= 8'h80) chk(rs, {24'h0, d}, "pulses");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (90000) @(posedge core_clk);
      errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      finish_test();
   end
   initial begin
      repeat (12) @(posedge core_clk);
      chk({28'h0, pin_a, pin_b}, 32'h0, "pins in reset");
      nrst <= 1'b1;
      measure(300);
      chk(dhi_a | dlo_a | dhi_b | dlo_b, 32'h0, "pins after reset");
      axi_rd(IDX_DUTY_A, rd, rsp);
      chk(rd, 32'h0, "duty reset");
      axi_rd(IDX_CONFIG, rd, rsp);
      chk(rd, 32'h0, "config reset");
      axi_wr(IDX_DUTY_B, 8'hA5, rsp);
      axi_rd(IDX_DUTY_B, rd, rsp);
      chk({rd[29:0], rsp}, {30'hA5, RESP_OKAY}, "readback");
      axi_wr(IDX_STATUS, 8'h01, rsp);
      chk(32'(rsp), 32'(RESP_SLVERR), "status write");
      axi_rd(8'h10, rd, rsp);
      chk({rd[29:0], rsp}, {30'h0, RESP_SLVERR}, "unmapped read");
      axi_rd(IDX_STATUS, rd, rsp);
      chk({rd[31:3], rsp, 1'b0}, {29'h0, RESP_OKAY, 1'b0}, "status read");
      for (int i = 0; i < 6; i++) begin
         axi_wr(IDX_DUTY_A, rows[i].da, rsp);
         axi_wr(IDX_DUTY_B, rows[i].db, rsp);
         axi_wr(IDX_CONFIG, {6'h00, rows[i].f}, rsp);
         axi_wr(IDX_STYLE, {4'h0, rows[i].sb, rows[i].sa}, rsp);
         pull_a <= (rows[i].sa == 2'h1);
         pull_b <= (rows[i].sb == 2'h1);
         per = 256 << (3 * rows[i].f);
         repeat (2 * per) @(posedge core_clk);
         measure(per);
         chk_line(hi_a, dhi_a, dlo_a, rs_a, rows[i].da, rows[i].f, rows[i].sa);
         chk_line(hi_b, dhi_b, dlo_b, rs_b, rows[i].db, rows[i].f, rows[i].sb);
      end
      // Line a push/pull, line b open drain with pull-up, both in tone mode
      axi_wr(IDX_STYLE, 8'h07, rsp);
      pull_b <= 1'b1;
      axi_wr(IDX_CONFIG, 8'h30, rsp);
      repeat (4 * TONE_HALF) @(posedge core_clk);
      measure(2 * TONE_HALF);
      chk(hi_a, 32'(TONE_HALF), "tone high");
      chk(rs_a, 32'h1, "tone edges");
      chk(dlo_a, 32'(TONE_HALF), "tone low");
      chk(hi_b, 32'(TONE_HALF), "tone b high");
      chk(dhi_b, 32'h0, "tone b drain");
      chk(dlo_b, 32'(TONE_HALF), "tone b low");
      // Second reset in mid-run, held long enough for the sampled-value checks
      @(posedge core_clk);
      nrst <= 1'b0;
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      measure(300);
      chk(dhi_a | dlo_a | dhi_b | dlo_b, 32'h0, "pins after mid reset");
      axi_rd(IDX_DUTY_A, rd, rsp);
      chk(rd, 32'h0, "duty mid reset");
      axi_rd(IDX_CONFIG, rd, rsp);
      chk(rd, 32'h0, "config mid reset");
      finish_test();
   end
endmodule
